// ---- pdwl_map.svh ----
// Purpose: Constants for the peripheral-disable write lock.
// Assumes: Included by its bare name.
// Notes:   Bit positions, reset values and the disable word count.
`ifndef PDWL_MAP_SVH
`define PDWL_MAP_SVH
`define PDWL_LOCK_BIT      5'd12
`define PDWL_ONE_WAY_BIT   5'd28
`define PDWL_CFG_RST       32'h0000_0000
`define PDWL_PMD_RST       32'h0000_0000
`define PDWL_LOCK_RST      1'b0
`define PDWL_NUM_PMD       6
`endif

// ---- pdwl_pkg.sv ----
// Purpose: Types for the peripheral-disable write lock.
// Assumes: Nothing beyond the map header.
// Notes:   Write request carrier.
package pdwl_pkg;
  typedef struct packed {
    logic        valid;
    logic [2:0]  sel;
    logic [31:0] data;
  } pdwl_wr_t;
endpackage

// ---- pdwl_lock.sv ----
// Purpose: Write lock for the peripheral-module-disable registers.
//          Holds six disable words and the lock bit that guards them.
// Assumes: Writes are single-cycle and synchronous to mclk; unlock is a one-cycle pulse.
//          The one-way option word is static while the device runs.
//          Any write is offered for exactly one cycle, never held.
// Notes:   Writes always complete; blocked ones just do not store.
//          The acknowledge never tells a stored write from a dropped one,
//          so software cannot probe the lock through the bus response.
//          Selects six and seven address no word; they are acked only.
//          The lock bit is driven straight from its flop, as the config
//          control register would show it to a read.
//          Reset is the only path back to an open state under one-way.
// Notes on behaviour
// - Lock set means disable register writes are dropped, contents held.
// - Blocked writes finish normally; no error is ever signalled.
// - Lock is bit 12 of config control; one blocks, zero permits.
// - Lock bit changes only after a completed unlock sequence.
// - With one-way option active, lock cannot clear once set.
// - One-way held lock makes unlock useless until device reset.
// - Only device reset clears a sticky one-way lock.
`timescale 1ns/1ps
`include "pdwl_map.svh"
module pdwl_lock (
  input  wire logic              mclk,
  input  wire logic              rstn,
  input  wire pdwl_pkg::pdwl_wr_t pmd_wr,
  input  wire logic              cfg_wr,
  input  wire logic [31:0]       cfg_wdata,
  input  wire logic              unlock_ok,
  input  wire logic [31:0]       device_config_word_three,
  output logic                   disable_reg_lock,
  output logic                   wr_done,
  output logic [`PDWL_NUM_PMD*32-1:0] periph_disable_regs
);
  import pdwl_pkg::*;

  // Select decode shared by the store path and its checks, so
  // both always agree on which word a request addresses.
  // Selects past the last word match nothing and store nowhere.
  function automatic logic pmd_sel_hit(input logic [2:0] sel, input int unsigned idx);
    pmd_sel_hit = (sel == 3'(idx));
  endfunction

  // Local state; the lock and the six words share one reset
  logic [1:0]  rst_sync_ff;
  logic        rst_n;
  logic        lock_ff;
  logic        done_ff;
  logic [31:0] pmd_ff [`PDWL_NUM_PMD];

  // Reset entry is immediate; release waits two edges so every
  // flop leaves reset on the same clock edge.
  // Reset released through two flops
  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      rst_sync_ff <= 2'b00;
    end else begin
      rst_sync_ff <= {rst_sync_ff[0], 1'b1};
    end
  end
  assign rst_n = rst_sync_ff[1];

  // Lock decode. The one-way option is read live from the config word,
  // so a change there acts on the next lock write; the word is meant
  // to stay fixed while the device runs.
  wire lock_one_way = device_config_word_three[`PDWL_ONE_WAY_BIT];
  wire req_lock     = cfg_wdata[`PDWL_LOCK_BIT];
  // Without the qualifier a lock write is acked but changes nothing
  // unlock gating
  wire lock_wr_ok   = cfg_wr && unlock_ok;
  // Only a clear is refused under one-way; a set is always taken
  // sticky one-way
  wire clr_blocked  = lock_one_way && lock_ff;
  wire nxt_lock     = (lock_wr_ok && !(clr_blocked && !req_lock)) ? req_lock : lock_ff;
  // The gate reads the lock flop, so a word write in the same cycle
  // as a lock write is judged by the old lock value.
  // write gate
  wire pmd_wr_en    = pmd_wr.valid && !lock_ff;

  // Lock bit; under one-way only reset brings it back to open
  // reset clears lock
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      lock_ff <= `PDWL_LOCK_RST;
    end else begin
      lock_ff <= nxt_lock;
    end
  end

  // A refused write gets the same ack, so the lock cannot be probed
  // every write acknowledged, stored or not
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      done_ff <= 1'b0;
    end else begin
      done_ff <= pmd_wr.valid || cfg_wr;
    end
  end

  // One storage word per disable register; the flat output
  // is only a view of the array, word i at bits i*32 up.
  genvar i;
  generate
    for (i = 0; i < `PDWL_NUM_PMD; i++) begin : g_pmd
      wire pmd_hit = pmd_wr_en && pmd_sel_hit(pmd_wr.sel, i);
      always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
          pmd_ff[i] <= `PDWL_PMD_RST;
        end else if (pmd_hit) begin
          pmd_ff[i] <= pmd_wr.data;
        end
      end
      assign periph_disable_regs[i*32 +: 32] = pmd_ff[i];

      pmd_keep_a: assert property (@(posedge mclk) disable iff (!rst_n)
        !(pmd_wr.valid && !disable_reg_lock && pmd_sel_hit(pmd_wr.sel, i)) |=> $stable(pmd_ff[i]))
        else $error("disable register changed without a write");
      pmd_store_a: assert property (@(posedge mclk) disable iff (!rst_n)
        (pmd_wr.valid && !disable_reg_lock && pmd_sel_hit(pmd_wr.sel, i)) |=> pmd_ff[i] == $past(pmd_wr.data))
        else $error("open write not stored");
    end
  endgenerate

  // Outputs straight from their flops, no logic after them
  assign disable_reg_lock = lock_ff;
  assign wr_done          = done_ff;

  // Checks on the stored state; none depends on bus timing, since
  // every request here lasts exactly one cycle.
  // Blocked write leaves register as it was
  pmd_hold_a: assert property (@(posedge mclk) disable iff (!rst_n)
    (pmd_wr.valid && lock_ff) |=> $stable(periph_disable_regs))
    else $error("locked disable register changed");
  wr_ack_a: assert property (@(posedge mclk) disable iff (!rst_n)
    pmd_wr.valid |=> wr_done)
    else $error("write not acknowledged");
  lock_need_unlock_a: assert property (@(posedge mclk) disable iff (!rst_n)
    !unlock_ok |=> $stable(disable_reg_lock))
    else $error("lock changed without unlock");
  one_way_hold_a: assert property (@(posedge mclk) disable iff (!rst_n)
    (lock_one_way && lock_ff) |=> lock_ff)
    else $error("one-way lock cleared");
  open_write_a: assert property (@(posedge mclk) disable iff (!rst_n)
    (pmd_wr.valid && !lock_ff && pmd_wr.sel == 3'd0) |=> periph_disable_regs[31:0] == $past(pmd_wr.data))
    else $error("unlocked write not stored");
  lock_set_a: assert property (@(posedge mclk) disable iff (!rst_n)
    (cfg_wr && unlock_ok && req_lock) |=> disable_reg_lock)
    else $error("lock not set");

  // Lock request shapes. Each names one cycle of a request, so the
  // checks below read as the rule that they guard. A refused clear
  // and a taken set differ only in the data bit and the current lock state.
  sequence lock_req_s;
    cfg_wr && unlock_ok;
  endsequence

  sequence clear_try_s;
    lock_req_s ##0 !req_lock;
  endsequence

  sequence sticky_s;
    lock_one_way && disable_reg_lock;
  endsequence

  lock_clear_a: assert property (@(posedge mclk) disable iff (!rst_n)
    clear_try_s ##0 !lock_one_way |=> !disable_reg_lock)
    else $error("lock not cleared");

  one_way_refuse_a: assert property (@(posedge mclk) disable iff (!rst_n)
    sticky_s ##0 clear_try_s |=> disable_reg_lock)
    else $error("one-way lock cleared by unlocked write");

  one_way_set_a: assert property (@(posedge mclk) disable iff (!rst_n)
    lock_req_s ##0 (req_lock && lock_one_way) |=> disable_reg_lock)
    else $error("one-way lock not set");

  sticky_unlock_a: assert property (@(posedge mclk) disable iff (!rst_n)
    sticky_s ##0 lock_req_s |=> disable_reg_lock && $stable(periph_disable_regs))
    else $error("unlock opened a one-way lock");

  lock_qual_a: assert property (@(posedge mclk) disable iff (!rst_n)
    $changed(disable_reg_lock) |-> $past(lock_wr_ok))
    else $error("lock changed without qualifier");

  lock_idle_a: assert property (@(posedge mclk) disable iff (!rst_n)
    !cfg_wr |=> $stable(disable_reg_lock))
    else $error("lock changed without a config write");

  bare_cfg_a: assert property (@(posedge mclk) disable iff (!rst_n)
    (cfg_wr && !unlock_ok) |=> $stable(disable_reg_lock))
    else $error("lock changed by a write without unlock");

  cfg_ack_a: assert property (@(posedge mclk) disable iff (!rst_n)
    cfg_wr |=> wr_done)
    else $error("config write not acknowledged");

  blocked_ack_a: assert property (@(posedge mclk) disable iff (!rst_n)
    (pmd_wr.valid && disable_reg_lock) |=> wr_done && $stable(periph_disable_regs))
    else $error("blocked write not completed quietly");

  ack_pulse_a: assert property (@(posedge mclk) disable iff (!rst_n)
    !(pmd_wr.valid || cfg_wr) |=> !wr_done)
    else $error("acknowledge without a write");

  reset_open_a: assert property (@(posedge mclk) disable iff (!rst_n)
    $rose(rst_n) |-> !disable_reg_lock && !wr_done && periph_disable_regs == '0)
    else $error("state not cleared by reset");
endmodule

// ---- pdwl_tb.sv ----
// Purpose: Self-checking bench for the disable-register write lock.
// Assumes: Inputs change on falling edges.
// Notes:   Table rows first, sticky lock included; reset by hand.
`timescale 1ns/1ps
module tb;
  import pdwl_pkg::*;
  typedef struct packed {
    logic c, u, l, w, v;
    logic [2:0]  s;
    logic [31:0] d;
    logic        el;
    logic [31:0] er;
  } pdwl_row_t;
  logic          mclk = 0, rstn = 0, cfg_wr = 0, unlock_ok = 0, disable_reg_lock, wr_done;
  pdwl_wr_t      pmd_wr = '0;
  logic [31:0]   cfg_wdata = '0, cfg3 = '0;
  logic [191:0]  regs;
  int            error_cnt = 0, n_compared = 0, cyc = 0;
  pdwl_row_t     rows [9];
  pdwl_lock u_pdwl_lock (.mclk(mclk), .rstn(rstn), .pmd_wr(pmd_wr), .cfg_wr(cfg_wr), .cfg_wdata(cfg_wdata),
    .unlock_ok(unlock_ok), .device_config_word_three(cfg3), .disable_reg_lock(disable_reg_lock),
    .wr_done(wr_done), .periph_disable_regs(regs));
  // Compare and count
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    n_compared++;
    if (seen !== exp) begin
      error_cnt++;
      $display("[ERR] %0t seen %h exp %h", $time, seen, exp);
    end
  endtask
  task automatic stop_test;
    if (error_cnt == 0 && n_compared > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask
  // One write cycle checked, then one idle cycle
  task automatic step(input pdwl_row_t r);
    cfg_wr = r.c;
    unlock_ok = r.u;
    cfg_wdata = 32'(r.l) << 12;
    cfg3 = 32'(r.w) << 28;
    pmd_wr = '{r.v, r.s, r.d};
    @(negedge mclk);
    chk(wr_done, 1); // always acked
    chk(disable_reg_lock, r.el); // lock value
    chk(regs[r.s*32+:32], r.er); // word contents as expected
    cfg_wr = 0;
    unlock_ok = 0;
    pmd_wr.valid = 0;
    @(negedge mclk);
    chk(wr_done, 0); // one-cycle ack
  endtask
  initial forever #12.5 mclk = ~mclk;
  // Hang guard, well above the run length
  always @(posedge mclk) begin
    cyc <= cyc + 1;
    if (cyc == 400) begin
      error_cnt++;
      stop_test;
    end
  end
  initial begin
    rows = '{'{0,0,0,0,1,0,8'ha1,0,8'ha1}, '{1,0,1,0,0,0,0,0,8'ha1}, '{1,1,1,0,0,0,0,1,8'ha1},
      '{0,0,0,0,1,0,8'hb2,1,8'ha1}, '{1,1,0,0,0,0,0,0,8'ha1}, '{0,0,0,0,1,5,8'hc3,0,8'hc3},
      '{1,1,1,1,0,5,0,1,8'hc3}, '{1,1,0,1,0,5,0,1,8'hc3}, '{0,0,0,1,1,5,8'hd4,1,8'hc3}};
    repeat (3) @(negedge mclk);
    rstn = 1;
    repeat (3) @(negedge mclk);
    chk(regs[191:160], 0); // word 5 starts clear
    chk(disable_reg_lock, 0); // lock starts clear
    foreach (rows[i]) step(rows[i]); // plain rows, then one-way rows
    rstn = 0;
    @(negedge mclk);
    chk(disable_reg_lock, 0); // reset clears
    chk(regs[191:160], 0); // words reset
    rstn = 1;
    repeat (3) @(negedge mclk);
    step('{0,0,0,1,1,5,8'he5,0,8'he5}); // writable after reset
    stop_test;
  end
endmodule
